/* File: hw/iqn_regs.sv */
// Our own choice: the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module iqn_regs #(
  parameter int SAMPLE_W = 16,
  parameter int ADDR_W   = 8
) (
  // Clock and reset
  input  wire logic                hclk,
  input  wire logic                hresetn,
  // AHB-Lite slave
  input  wire logic                hsel,
  input  wire logic [ADDR_W-1:0]   haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic      [31:0]         hrdata,
  output logic                     hreadyout,
  output logic                     hresp,
  // CD sample path
  input  wire logic [SAMPLE_W-1:0] c_sample,
  input  wire logic [SAMPLE_W-1:0] d_sample,
  output logic      [SAMPLE_W-1:0] c_corrected,
  output logic      [SAMPLE_W-1:0] d_delayed,
  // Active CD gain and offset words for the correction datapath
  output logic      [15:0]         cd_gain_offset_a_active,
  output logic      [15:0]         cd_gain_offset_b_active,
  // Oscillator table addresses
  output logic      [15:0]         ab_lut_addr,
  output logic      [15:0]         cd_lut_addr
);

  generate
    if (SAMPLE_W < 2 || SAMPLE_W > 32) begin : g_bad_sample_w
      $error("iqn_regs: SAMPLE_W must lie between 2 and 32");
    end
    if (ADDR_W < 8 || ADDR_W > 32) begin : g_bad_addr_w
      $error("iqn_regs: ADDR_W must lie between 8 and 32");
    end
  endgenerate

  typedef enum logic [1:0] {
    IQN_IDLE,
    IQN_WRITE,
    IQN_READ_WAIT,
    IQN_READ_DONE
  } iqn_bus_e;

  iqn_bus_e            bus_state;
  logic [ADDR_W-1:0]   dp_addr;
  logic                addr_take;
  logic                wr_commit;
  logic [5:0]          wr_idx;
  logic                idx_ok;
  logic [15:0]         wdat;

  // Staging copies and auto-sync enables
  logic [15:0]         cd_stage_a;
  logic [15:0]         cd_stage_b;
  logic [11:0]         cd_phase_stage;
  logic [15:0]         ab_shift_stage;
  logic [15:0]         cd_shift_stage;
  logic [31:0]         ab_freq_stage;
  logic [31:0]         cd_freq_stage;
  logic                corr_sync_en;
  logic                mix_sync_en;

  // Active copies
  logic [11:0]         cd_phase_active;

  logic                corr_sync;
  logic                ab_mix_sync;
  logic                cd_mix_sync;

  // Oscillator channels: index 0 is AB, index 1 is CD
  localparam int       NUM_OSC = 2;
  logic [NUM_OSC-1:0]  mix_sync;

  // Bus front end
  assign addr_take = hsel && hready && (htrans == iqn_pkg::HTRANS_NONSEQ || htrans == 2'h3);
  assign hresp     = iqn_pkg::HRESP_OKAY;
  assign hreadyout = (bus_state != IQN_READ_WAIT);

  // Reads get one wait state so a write in the preceding data phase is already visible
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_state <= IQN_IDLE;
    end else begin
      case (bus_state)
        IQN_READ_WAIT: begin
          bus_state <= IQN_READ_DONE;
        end
        IQN_IDLE, IQN_WRITE, IQN_READ_DONE: begin
          if (addr_take) begin
            bus_state <= hwrite ? IQN_WRITE : IQN_READ_WAIT;
          end else begin
            bus_state <= IQN_IDLE;
          end
        end
        default: begin
          bus_state <= IQN_IDLE;
        end
      endcase
    end
  end

  // Data-phase address; a stalled read data phase accepts no new address
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_addr <= '0;
    end else if (addr_take && (bus_state != IQN_READ_WAIT)) begin
      dp_addr <= haddr;
    end
  end

  assign idx_ok    = (dp_addr[1:0] == 2'h0) && (dp_addr[ADDR_W-1:2] < 64);
  assign wr_idx    = dp_addr[7:2];
  assign wr_commit = (bus_state == IQN_WRITE) && idx_ok;
  assign wdat      = hwdata[15:0];

  // Only the trigger register raises a load; staging writes alone never do
  assign corr_sync   = wr_commit && (wr_idx == iqn_pkg::IDX_CD_PHASE) && corr_sync_en;
  assign ab_mix_sync = wr_commit && (wr_idx == iqn_pkg::IDX_AB_SHIFT) && mix_sync_en;
  assign cd_mix_sync = wr_commit && (wr_idx == iqn_pkg::IDX_CD_SHIFT) && mix_sync_en;

  // Auto-sync enables, bit 0 of each enable register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      corr_sync_en <= 1'b0;
      mix_sync_en  <= 1'b0;
    end else if (wr_commit) begin
      if (wr_idx == iqn_pkg::IDX_CORR_SYNC_EN) begin
        corr_sync_en <= wdat[iqn_pkg::SYNC_EN_BIT];
      end
      if (wr_idx == iqn_pkg::IDX_MIX_SYNC_EN) begin
        mix_sync_en <= wdat[iqn_pkg::SYNC_EN_BIT];
      end
    end
  end

  // CD correction staging keeps the last written value
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cd_stage_a     <= iqn_pkg::RST_STAGE;
      cd_stage_b     <= iqn_pkg::RST_STAGE;
      cd_phase_stage <= iqn_pkg::RST_PHASE;
    end else if (wr_commit) begin
      case (wr_idx)
        iqn_pkg::IDX_CD_STAGE_A: cd_stage_a     <= wdat;
        iqn_pkg::IDX_CD_STAGE_B: cd_stage_b     <= wdat;
        iqn_pkg::IDX_CD_PHASE:   cd_phase_stage <= wdat[iqn_pkg::PHASE_W-1:0];
        default: begin
        end
      endcase
    end
  end

  // Mixer staging: phase shifts and both halves of each frequency word
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ab_shift_stage <= iqn_pkg::RST_ZERO;
      cd_shift_stage <= iqn_pkg::RST_ZERO;
      ab_freq_stage  <= {iqn_pkg::RST_ZERO, iqn_pkg::RST_ZERO};
      cd_freq_stage  <= {iqn_pkg::RST_ZERO, iqn_pkg::RST_ZERO};
    end else if (wr_commit) begin
      case (wr_idx)
        iqn_pkg::IDX_AB_SHIFT:   ab_shift_stage       <= wdat;
        iqn_pkg::IDX_CD_SHIFT:   cd_shift_stage       <= wdat;
        iqn_pkg::IDX_AB_FREQ_LO: ab_freq_stage[15:0]  <= wdat;
        iqn_pkg::IDX_AB_FREQ_HI: ab_freq_stage[31:16] <= wdat;
        iqn_pkg::IDX_CD_FREQ_LO: cd_freq_stage[15:0]  <= wdat;
        iqn_pkg::IDX_CD_FREQ_HI: cd_freq_stage[31:16] <= wdat;
        default: begin
        end
      endcase
    end
  end

  // Active CD correction set; the phase word comes straight from the bus so the
  // value being written is the one loaded, not the previous staging copy
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cd_phase_active         <= iqn_pkg::RST_PHASE;
      cd_gain_offset_a_active <= iqn_pkg::RST_STAGE;
      cd_gain_offset_b_active <= iqn_pkg::RST_STAGE;
    end else if (corr_sync) begin
      cd_phase_active         <= wdat[iqn_pkg::PHASE_W-1:0];
      cd_gain_offset_a_active <= cd_stage_a;
      cd_gain_offset_b_active <= cd_stage_b;
    end
  end

  assign mix_sync = {cd_mix_sync, ab_mix_sync};

  // One oscillator per channel; the accumulator keeps running across a load so
  // the phase stays continuous, at the cost of no phase reset on retune
  for (genvar ch = 0; ch < NUM_OSC; ch++) begin : g_osc
    logic [31:0] freq_in;
    logic [15:0] shift_active;
    logic [31:0] freq_active;
    logic [31:0] acc;
    logic [15:0] lut_q;

    assign freq_in = (ch == 0) ? ab_freq_stage : cd_freq_stage;

    // Shift comes straight from the bus, frequency from the staged pair
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        shift_active <= iqn_pkg::RST_ZERO;
        freq_active  <= {iqn_pkg::RST_ZERO, iqn_pkg::RST_ZERO};
      end else if (mix_sync[ch]) begin
        shift_active <= wdat;
        freq_active  <= freq_in;
      end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        acc <= '0;
      end else begin
        acc <= acc + freq_active;
      end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        lut_q <= '0;
      end else begin
        lut_q <= acc[31:16] + shift_active;
      end
    end
  end

  assign ab_lut_addr = g_osc[0].lut_q;
  assign cd_lut_addr = g_osc[1].lut_q;

  // Phase correction: word scaled by 2^-12, product added into C with saturation
  logic signed [SAMPLE_W+iqn_pkg::PHASE_W-1:0] corr_prod;
  logic signed [SAMPLE_W-1:0]                  corr_term;
  logic signed [SAMPLE_W:0]                    corr_sum;
  logic signed [SAMPLE_W:0]                    sat_max;
  logic signed [SAMPLE_W:0]                    sat_min;

  assign corr_prod = $signed(cd_phase_active) * $signed(d_sample);
  assign corr_term = SAMPLE_W'(corr_prod >>> iqn_pkg::PHASE_FRAC);
  assign corr_sum  = (SAMPLE_W+1)'($signed(c_sample)) + (SAMPLE_W+1)'(corr_term);
  assign sat_max   = (SAMPLE_W+1)'({2'b00, {(SAMPLE_W-1){1'b1}}});
  assign sat_min   = (SAMPLE_W+1)'({2'b11, {(SAMPLE_W-1){1'b0}}});

  logic [SAMPLE_W-1:0]                         next_c_corrected;

  // Saturating rather than wrapping keeps a large correction from flipping the sign
  always_comb begin
    if (corr_sum > sat_max) begin
      next_c_corrected = sat_max[SAMPLE_W-1:0];
    end else if (corr_sum < sat_min) begin
      next_c_corrected = sat_min[SAMPLE_W-1:0];
    end else begin
      next_c_corrected = corr_sum[SAMPLE_W-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      c_corrected <= '0;
    end else begin
      c_corrected <= next_c_corrected;
    end
  end

  // D leaves with the same one-cycle latency as corrected C so the pair stays aligned
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      d_delayed <= '0;
    end else begin
      d_delayed <= d_sample;
    end
  end

  // Read path
  function automatic logic [15:0] read_reg(input logic [5:0] idx);
    logic [15:0] v;
    v = 16'h0000;
    case (idx)
      iqn_pkg::IDX_CD_STAGE_A:    v = cd_stage_a;
      iqn_pkg::IDX_CD_STAGE_B:    v = cd_stage_b;
      iqn_pkg::IDX_CD_PHASE:      v = {4'h0, cd_phase_stage};
      iqn_pkg::IDX_AB_SHIFT:      v = ab_shift_stage;
      iqn_pkg::IDX_CD_SHIFT:      v = cd_shift_stage;
      iqn_pkg::IDX_AB_FREQ_LO:    v = ab_freq_stage[15:0];
      iqn_pkg::IDX_AB_FREQ_HI:    v = ab_freq_stage[31:16];
      iqn_pkg::IDX_CD_FREQ_LO:    v = cd_freq_stage[15:0];
      iqn_pkg::IDX_CD_FREQ_HI:    v = cd_freq_stage[31:16];
      iqn_pkg::IDX_CORR_SYNC_EN:  v = {15'h0000, corr_sync_en};
      iqn_pkg::IDX_MIX_SYNC_EN:   v = {15'h0000, mix_sync_en};
      iqn_pkg::IDX_ACT_CD_PHASE:  v = {4'h0, cd_phase_active};
      iqn_pkg::IDX_AB_LUT_STATUS: v = ab_lut_addr;
      default:                    v = 16'h0000;
    endcase
    return v;
  endfunction : read_reg

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= '0;
    end else if (bus_state == IQN_READ_WAIT) begin
      hrdata <= idx_ok ? {16'h0000, read_reg(wr_idx)} : 32'h0000_0000;
    end
  end

  // hsize is not decoded: every access is treated as a whole word
  logic unused_ok;
  assign unused_ok = &{1'b0, hsize};

endmodule : iqn_regs
`default_nettype wire

/* File: hw/iqn_pkg.sv */
// What this block does
// - CD phase word is 12-bit two's complement, span -0.5 to under +0.5, resets zero.
// - Active CD phase word times D sample is added into the C sample.
// - CD phase write with correction sync enabled loads CD gain, offset, phase together.
// - CD gain and offset staging writes alone leave active CD correction unchanged.
// - Bits 15 to 12 of the CD phase register are reserved and read zero.
// - AB phase offset adds to upper AB accumulator half; sum addresses the tables.
// - CD phase offset adds to upper CD accumulator half; sum addresses the tables.
// - AB offset write with mixer sync enabled loads AB offset and frequency together.
// - AB frequency staging writes alone leave the active AB mixer unchanged.
// - CD offset write with mixer sync enabled loads CD offset and frequency together.
// - CD frequency staging writes alone leave the active CD mixer unchanged.
// - CD phase register and both offset registers reset to all zeros.
// - Frequency words are 32-bit two's complement, low half then high half register.
package iqn_pkg;

  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_CD_STAGE_A    = 6'h0E;
  localparam logic [5:0] IDX_CD_STAGE_B    = 6'h0F;
  localparam logic [5:0] IDX_CD_PHASE      = 6'h11;
  localparam logic [5:0] IDX_AB_SHIFT      = 6'h12;
  localparam logic [5:0] IDX_CD_SHIFT      = 6'h13;
  localparam logic [5:0] IDX_AB_FREQ_LO    = 6'h14;
  localparam logic [5:0] IDX_AB_FREQ_HI    = 6'h15;
  localparam logic [5:0] IDX_CD_FREQ_LO    = 6'h16;
  localparam logic [5:0] IDX_CD_FREQ_HI    = 6'h17;
  localparam logic [5:0] IDX_CORR_SYNC_EN  = 6'h1E;
  localparam logic [5:0] IDX_MIX_SYNC_EN   = 6'h1F;
  localparam logic [5:0] IDX_ACT_CD_PHASE  = 6'h20;
  localparam logic [5:0] IDX_AB_LUT_STATUS = 6'h21;

  // Field layout
  localparam int         PHASE_W       = 12;
  localparam int         SYNC_EN_BIT   = 0;
  localparam int         PHASE_FRAC    = 12;

  // Reset values
  localparam logic [15:0] RST_ZERO     = 16'h0000;
  localparam logic [15:0] RST_STAGE    = 16'h0400;
  localparam logic [11:0] RST_PHASE    = 12'h000;

  // Bus encodings
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
  localparam logic        HRESP_OKAY    = 1'h0;

endpackage : iqn_pkg

/* File: tb/iqn_regs_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module iqn_regs_monitor #(
  parameter int SAMPLE_W = 16,
  parameter int ADDR_W   = 8
) (
  // Clock, reset and bus
  input wire logic                hclk,
  input wire logic                hresetn,
  input wire logic                hsel,
  input wire logic [ADDR_W-1:0]   haddr,
  input wire logic [1:0]          htrans,
  input wire logic                hwrite,
  input wire logic [2:0]          hsize,
  input wire logic [31:0]         hwdata,
  input wire logic                hready,
  input wire logic [31:0]         hrdata,
  input wire logic                hreadyout,
  input wire logic                hresp,
  // Datapath
  input wire logic [SAMPLE_W-1:0] c_sample,
  input wire logic [SAMPLE_W-1:0] d_sample,
  input wire logic [SAMPLE_W-1:0] c_corrected,
  input wire logic [SAMPLE_W-1:0] d_delayed,
  input wire logic [15:0]         cd_gain_offset_a_active,
  input wire logic [15:0]         cd_gain_offset_b_active,
  input wire logic [15:0]         ab_lut_addr,
  input wire logic [15:0]         cd_lut_addr
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic              ph_rd;
  logic              ph_wr;
  logic              corr_en;
  logic              mix_en;
  logic [ADDR_W-1:0] ph_a;
  logic [15:0]       stage_a_q;
  logic [15:0]       ab_hi_q;
  logic [15:0]       cd_hi_q;
  logic [11:0]       act_ph_q;
  wire logic         wr_done = ph_wr && hready;
  wire logic         rd_done = ph_rd && hreadyout;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_rd <= 1'b0;
      ph_wr <= 1'b0;
      ph_a  <= '0;
    end else if (hsel && hready && htrans[1]) begin
      ph_rd <= !hwrite;
      ph_wr <= hwrite;
      ph_a  <= haddr;
    end else if (hready) begin
      ph_rd <= 1'b0;
      ph_wr <= 1'b0;
    end
  end
  // Shadow of software state; assumes no pipelined write right behind a trigger
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      corr_en   <= 1'b0;
      mix_en    <= 1'b0;
      stage_a_q <= iqn_pkg::RST_STAGE;
      ab_hi_q   <= 16'h0000;
      cd_hi_q   <= 16'h0000;
      act_ph_q  <= 12'h000;
    end else if (wr_done) begin
      case (ph_a)
        8'h38: stage_a_q <= hwdata[15:0];
        8'h54: ab_hi_q <= hwdata[15:0];
        8'h5C: cd_hi_q <= hwdata[15:0];
        8'h78: corr_en <= hwdata[0];
        8'h7C: mix_en <= hwdata[0];
        8'h44: act_ph_q <= corr_en ? hwdata[11:0] : act_ph_q;
        default: ;
      endcase
    end
  end
  property p_rsv; rd_done && ph_a == 8'h44 |-> hrdata[31:12] == 20'h00000; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved phase bits not zero");
  property p_stage; rd_done && ph_a == 8'h38 |-> hrdata == {16'h0000, stage_a_q}; endproperty
  a_stage: assert property (p_stage) else $error("staging read wrong");
  property p_act; rd_done && ph_a == 8'h80 |-> hrdata[11:0] == act_ph_q; endproperty
  a_act: assert property (p_act) else $error("active phase word wrong");
  property p_load; wr_done && ph_a == 8'h44 && corr_en |=> cd_gain_offset_a_active == stage_a_q;
  endproperty
  a_load: assert property (p_load) else $error("correction sync did not load");
  property p_hold; !(wr_done && ph_a == 8'h44 && corr_en) |=>
    $stable(cd_gain_offset_a_active) && $stable(cd_gain_offset_b_active); endproperty
  a_hold: assert property (p_hold) else $error("active correction moved");
  property p_ab; wr_done && ph_a == 8'h48 && mix_en |->
    ##3 16'(ab_lut_addr - $past(ab_lut_addr) - ab_hi_q) <= 16'h0001; endproperty
  a_ab: assert property (p_ab) else $error("AB step wrong after sync");
  property p_cd; wr_done && ph_a == 8'h4C && mix_en |->
    ##3 16'(cd_lut_addr - $past(cd_lut_addr) - cd_hi_q) <= 16'h0001; endproperty
  a_cd: assert property (p_cd) else $error("CD step wrong after sync");
  property p_rst; $rose(hresetn) |-> ab_lut_addr == 16'h0000 && cd_lut_addr == 16'h0000;
  endproperty
  a_rst: assert property (p_rst) else $error("table address not zero at reset");
  property p_okay; hresp == iqn_pkg::HRESP_OKAY; endproperty
  a_okay: assert property (p_okay) else $error("response not OKAY");
  c_corr: cover property (wr_done && ph_a == 8'h44 && corr_en);
  c_mix: cover property (wr_done && ph_a == 8'h4C && mix_en);
  c_rsv: cover property (rd_done && ph_a == 8'h44);
endmodule : iqn_regs_monitor
bind iqn_regs iqn_regs_monitor #(.SAMPLE_W(SAMPLE_W), .ADDR_W(ADDR_W)) u_iqn_regs_monitor (.*);
`default_nettype wire

/* File: tb/iqn_regs_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module iqn_regs_tb;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic [7:0]  haddr = 8'h00;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [15:0] c_sample = 16'h0000;
  logic [15:0] d_sample = 16'h0000;
  logic        hready;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic [15:0] c_corrected, d_dly, act_a, act_b, ab_lut_addr, cd_lut_addr;
  int          miscompares = 0;
  int          checked = 0;
  int          cycles = 0;
  assign hready = hreadyout;
  always #50 hclk = ~hclk;
  iqn_regs u_iqn_regs (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(), .c_sample(c_sample),
    .d_sample(d_sample), .c_corrected(c_corrected), .d_delayed(d_dly),
    .cd_gain_offset_a_active(act_a), .cd_gain_offset_b_active(act_b),
    .ab_lut_addr(ab_lut_addr), .cd_lut_addr(cd_lut_addr));
  task automatic conclude;
    if (miscompares == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : conclude
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // Byte address is four times the register index
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rv);
    htrans <= iqn_pkg::HTRANS_NONSEQ;
    haddr  <= a;
    hwrite <= wr;
    do @(negedge hclk); while (hreadyout !== 1'b1);
    @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(negedge hclk); while (hreadyout !== 1'b1);
    rv = hrdata;
    @(posedge hclk);
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [31:0] unused;
    xfer(1'b1, a, {16'h0000, d}, unused);
  endtask : wr
  task automatic rd_check(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    xfer(1'b0, a, 32'h0, v);
    check(what, v, exp);
  endtask : rd_check
  task automatic t_reset;
    rd_check("cd_phase", 8'h44, 32'h0);
    rd_check("ab_shift", 8'h48, 32'h0);
    rd_check("cd_shift", 8'h4C, 32'h0);
  endtask : t_reset
  task automatic t_stage;
    wr(8'h38, 16'h1234);
    wr(8'h44, 16'hFFFF);
    @(negedge hclk);
    check("act_a", act_a, 32'h0400);
    @(posedge hclk);
    wr(8'h45, 16'h0AAA);
    rd_check("cd_phase", 8'h44, 32'h0FFF);
    rd_check("act_phase", 8'h80, 32'h0);
    rd_check("stage_a", 8'h38, 32'h1234);
    rd_check("unmapped", 8'h40, 32'h0);
  endtask : t_stage
  // Phase written last so gain and offset words land with it
  task automatic dp(input logic [15:0] ph, input logic [15:0] c, input logic [15:0] d,
                    input logic [15:0] e);
    wr(8'h44, ph);
    c_sample <= c;
    d_sample <= d;
    repeat (3) @(posedge hclk);
    @(negedge hclk);
    check("c_corrected", c_corrected, e);
    check("d_delayed", d_dly, d);
    @(posedge hclk);
  endtask : dp
  task automatic t_corr;
    wr(8'h78, 16'h0001);
    wr(8'h3C, 16'h0ABC);
    dp(16'h0400, 16'h0100, 16'h0100, 16'h0140);
    check("act_a", act_a, 32'h1234);
    check("act_b", act_b, 32'h0ABC);
    rd_check("act_phase", 8'h80, 32'h0400);
    dp(16'h0400, 16'h0100, 16'hFF00, 16'h00C0);
    dp(16'h0800, 16'h0000, 16'h0100, 16'hFF80);
    dp(16'h07FF, 16'h7FFF, 16'h7FFF, 16'h7FFF);
  endtask : t_corr
  task automatic mixchk(input logic cd, input logic [7:0] a, input logic [15:0] sh,
                        input logic [15:0] hi);
    wr(a, sh);
    @(posedge hclk);
    @(negedge hclk);
    check("lut_now", cd ? cd_lut_addr : ab_lut_addr, sh);
    @(negedge hclk);
    check("lut_next", cd ? cd_lut_addr : ab_lut_addr, 16'(sh + hi));
    @(posedge hclk);
  endtask : mixchk
  task automatic t_mix;
    wr(8'h54, 16'h0001);
    wr(8'h50, 16'h0000);
    wr(8'h48, 16'h0100);
    wr(8'h5C, 16'hFFFF);
    wr(8'h58, 16'h0000);
    @(negedge hclk);
    check("ab_lut", ab_lut_addr, 32'h0);
    check("cd_lut", cd_lut_addr, 32'h0);
    @(posedge hclk);
    wr(8'h7C, 16'h0001);
    mixchk(1'b0, 8'h48, 16'h0100, 16'h0001);
    check("cd_lut", cd_lut_addr, 32'h0);
    mixchk(1'b1, 8'h4C, 16'h2000, 16'hFFFF);
  endtask : t_mix
  // Mid-run reset after both mixers and the correction set were loaded
  task automatic t_rerst;
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    @(negedge hclk);
    check("ab_lut", ab_lut_addr, 32'h0);
    check("cd_lut", cd_lut_addr, 32'h0);
    @(posedge hclk);
    t_reset();
    rd_check("act_phase", 8'h80, 32'h0);
    rd_check("lut_status", 8'h84, 32'h0);
  endtask : t_rerst
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      miscompares++;
      conclude();
    end
  end
  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_stage();
    t_corr();
    t_mix();
    t_rerst();
    conclude();
  end
endmodule : iqn_regs_tb
`default_nettype wire
